// ===== hw/system_clock_switching.sv
// System clock source selection and oscillator enable control
// ------------------------------------------------------------------
// Notes on behaviour
// - Writing 0x36 selects high-speed RC divided by two; low-speed stays on.
// - Writing 0xA6 selects the crystal; low-speed oscillator stays enabled.
// - Clearing mode bit 2 stops the low-speed RC oscillator.
// - One write of 0x50 from the low-speed source stops that clock and hangs the core.
// - Switching to the crystal is not checked; unstable crystal hangs.
// - Watchdog runs after reset; calibration routine turns it off.
// - Watchdog stops whenever the low-speed RC oscillator is off.
// - Mode bit 0 with pin as input makes pin active-low external reset.
// - Crystal control bits 6:5 select drive range, bit 7 enables crystal.
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module system_clock_switching
(
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire logic                   mode_wr,
  input  wire logic [clock_switch_pkg::MODE_W-1:0] mode_wdata,
  input  wire logic                   xctl_wr,
  input  wire logic [clock_switch_pkg::XCTL_W-1:0] xctl_wdata,
  input  wire logic                   crystal_stable,
  input  wire logic                   calibration_done,
  input  wire logic                   shared_pin_is_input,
  input  wire logic                   shared_pin_b,
  output logic [clock_switch_pkg::MODE_W-1:0] clock_mode_register,
  output logic [clock_switch_pkg::XCTL_W-1:0] crystal_control_register,
  output clock_switch_pkg::clk_src_t  system_clock_source,
  output logic                        low_speed_rc_enable,
  output logic                        high_speed_rc_enable,
  output logic                        crystal_enable,
  output clock_switch_pkg::drive_range_t crystal_drive_range,
  output logic                        watchdog_active,
  output logic                        core_hung,
  output logic                        external_reset_request
);
  import clock_switch_pkg::*;

  logic [MODE_W-1:0] mode_r;
  logic              hung_r;
  logic              hung_nxt;
  clk_src_t          src_r;
  clk_src_t          src_nxt;
  logic              src_osc_on;

  // ----------------------------------------------------------------
  // Crystal control register
  // ----------------------------------------------------------------
  crystal_control u_xtal (
    .clock   (clock),
    .rst_b   (rst_b),
    .wr_en   (xctl_wr),
    .wr_data (xctl_wdata),
    .value   (crystal_control_register),
    .enable  (crystal_enable),
    .range   (crystal_drive_range)
  );

  // ----------------------------------------------------------------
  // Clock mode register
  // ----------------------------------------------------------------
  // A hung core executes nothing, so mode writes are dropped once hung; crystal control writes still land.
  // A software write wins over the calibration watchdog clear.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_RESET;
    end else if (mode_wr && !hung_r) begin
      mode_r <= mode_wdata;
    end else if (calibration_done && !hung_r) begin
      mode_r[BIT_WDT_EN] <= 1'b0;
    end
  end

  assign clock_mode_register  = mode_r;
  assign low_speed_rc_enable  = mode_r[BIT_LS_EN];
  assign high_speed_rc_enable = mode_r[BIT_HS_EN];

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  always_comb begin
    case (mode_r[SEL_HI:SEL_LO])
      SEL_HS_DIV2: src_nxt = SRC_HS_DIV2;
      SEL_HS_DIV1: src_nxt = SRC_HS_DIV1;
      SEL_XTAL:    src_nxt = SRC_XTAL;
      SEL_LS:      src_nxt = SRC_LS;
      default:     src_nxt = SRC_HS_DIV4;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      src_r <= SRC_LS;
    end else if (!hung_r) begin
      src_r <= src_nxt;
    end
  end

  assign system_clock_source = src_r;

  // Whether the oscillator behind the running source is alive
  always_comb begin
    case (src_r)
      SRC_LS:   src_osc_on = mode_r[BIT_LS_EN];
      SRC_XTAL: src_osc_on = crystal_enable && crystal_stable;
      default:  src_osc_on = mode_r[BIT_HS_EN];
    endcase
  end

  // ----------------------------------------------------------------
  // Hang detection
  // ----------------------------------------------------------------
  // The handover runs on the old clock; if that clock dies in the same
  // write, or the new source never oscillates, nothing can recover but
  // a reset. No stability check guards the crystal path on purpose.
  always_comb begin
    hung_nxt = hung_r;
    if (!src_osc_on) begin
      hung_nxt = 1'b1;
    // Judged on the stored selection, not the lagging source register, so
    // clearing the old oscillator on the edge after the switch stays safe.
    end else if (mode_wr && src_nxt == SRC_LS && !mode_wdata[BIT_LS_EN]
                 && mode_wdata[SEL_HI:SEL_LO] != SEL_LS) begin
      hung_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hung_r <= 1'b0;
    end else begin
      hung_r <= hung_nxt;
    end
  end

  assign core_hung = hung_r;

  // ----------------------------------------------------------------
  // Watchdog gating and external reset
  // ----------------------------------------------------------------
  assign watchdog_active = mode_r[BIT_WDT_EN] && mode_r[BIT_LS_EN];

  assign external_reset_request = mode_r[BIT_EXT_RST_EN]
                                  && shared_pin_is_input && !shared_pin_b;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence write_hs_div2_s;
    mode_wr && !hung_r && mode_wdata == MODE_TO_HS_DIV2;
  endsequence

  sequence write_xtal_s;
    mode_wr && !hung_r && mode_wdata == MODE_TO_XTAL;
  endsequence

  // A later write may clear the low-speed bit, so it is judged one edge on
  sequence ls_kept_then_hs_s;
    low_speed_rc_enable ##1 system_clock_source == SRC_HS_DIV2;
  endsequence

  sequence ls_kept_then_xtal_s;
    low_speed_rc_enable ##1 system_clock_source == SRC_XTAL;
  endsequence

  hs_div2_switch_a: assert property (
    write_hs_div2_s |=> ls_kept_then_hs_s)
    else $error("write of 0x36 did not select divided high-speed source");

  xtal_switch_a: assert property (
    write_xtal_s |=> ls_kept_then_xtal_s)
    else $error("write of 0xa6 did not select the crystal");

  ls_stop_a: assert property (
    mode_wr && !hung_r && !mode_wdata[BIT_LS_EN] |=> !low_speed_rc_enable)
    else $error("low-speed oscillator still enabled after clear");

  bad_switch_hang_a: assert property (
    mode_wr && !hung_r && clock_mode_register[SEL_HI:SEL_LO] == SEL_LS
    && src_osc_on && mode_wdata == MODE_BAD_SWITCH |=> core_hung)
    else $error("write of 0x50 from low-speed source did not hang");

  xtal_unstable_hang_a: assert property (
    system_clock_source == SRC_XTAL && !crystal_stable |=> core_hung)
    else $error("unstable crystal source did not hang the core");

  hang_sticky_a: assert property (
    core_hung |=> core_hung && $stable(clock_mode_register))
    else $error("hung core recovered or changed mode without reset");

  wdt_calib_off_a: assert property (
    calibration_done && !mode_wr && !hung_r |=> !watchdog_active)
    else $error("calibration routine left the watchdog running");

  wdt_ls_gate_a: assert property (
    !low_speed_rc_enable |-> !watchdog_active)
    else $error("watchdog active with low-speed oscillator off");

  ext_reset_a: assert property (
    external_reset_request == (clock_mode_register[BIT_EXT_RST_EN]
      && shared_pin_is_input && !shared_pin_b))
    else $error("external reset request does not follow pin and bit");

  xtal_range_a: assert property (
    xctl_wr && xctl_wdata[RANGE_HI:RANGE_LO] == RANGE_HIGH_CODE
    |=> crystal_drive_range == DRIVE_HIGH
        && crystal_enable == $past(xctl_wdata[BIT_XTAL_EN]))
    else $error("crystal control write not reflected in range or enable");

  reset_source_a: assert property (
    $rose(rst_b) |-> system_clock_source == SRC_LS && low_speed_rc_enable)
    else $error("core not on low-speed oscillator after reset");

endmodule : system_clock_switching
`default_nettype wire

// ===== hw/clock_switch_pkg.sv
// Constants and types shared by the system clock switching logic
package clock_switch_pkg;

  // ----------------------------------------------------------------
  // Clock mode register layout
  // ----------------------------------------------------------------
  localparam int          MODE_W          = 8;
  localparam int          SEL_HI          = 7;
  localparam int          SEL_LO          = 5;
  localparam int          SEL_W           = SEL_HI - SEL_LO + 1;
  localparam int          BIT_HS_EN       = 4;
  localparam int          BIT_LS_EN       = 2;
  localparam int          BIT_WDT_EN      = 1;
  localparam int          BIT_EXT_RST_EN  = 0;
  localparam logic [7:0]  MODE_RESET      = 8'hf6;

  localparam logic [2:0]  SEL_HS_DIV2     = 3'h1;
  localparam logic [2:0]  SEL_HS_DIV1     = 3'h2;
  localparam logic [2:0]  SEL_XTAL        = 3'h5;
  localparam logic [2:0]  SEL_LS          = 3'h7;

  // Documented example codes
  localparam logic [7:0]  MODE_TO_HS_DIV2 = 8'h36;
  localparam logic [7:0]  MODE_TO_XTAL    = 8'ha6;
  localparam logic [7:0]  MODE_BAD_SWITCH = 8'h50;

  // ----------------------------------------------------------------
  // Crystal control register layout
  // ----------------------------------------------------------------
  localparam int          XCTL_W          = 8;
  localparam int          BIT_XTAL_EN     = 7;
  localparam int          RANGE_HI        = 6;
  localparam int          RANGE_LO        = 5;
  localparam logic [7:0]  XCTL_RESET      = 8'h00;
  localparam logic [1:0]  RANGE_LOW_CODE  = 2'h1;
  localparam logic [1:0]  RANGE_MID_CODE  = 2'h2;
  localparam logic [1:0]  RANGE_HIGH_CODE = 2'h3;

  typedef enum logic [2:0] {
    SRC_LS, SRC_HS_DIV1, SRC_HS_DIV2, SRC_HS_DIV4, SRC_XTAL
  } clk_src_t;

  typedef enum logic [1:0] {
    DRIVE_OFF, DRIVE_LOW, DRIVE_MID, DRIVE_HIGH
  } drive_range_t;

endpackage : clock_switch_pkg

// ===== hw/crystal_control.sv
// Crystal control register with drive range decode
`timescale 1ns/1ps
`default_nettype none
module crystal_control
(
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic                 wr_en,
  input  wire logic [clock_switch_pkg::XCTL_W-1:0] wr_data,
  output logic [clock_switch_pkg::XCTL_W-1:0]      value,
  output logic                      enable,
  output clock_switch_pkg::drive_range_t range
);
  import clock_switch_pkg::*;

  logic [XCTL_W-1:0] ctl_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= XCTL_RESET;
    end else if (wr_en) begin
      ctl_r <= wr_data;
    end
  end

  assign value  = ctl_r;
  assign enable = ctl_r[BIT_XTAL_EN];

  always_comb begin
    case (ctl_r[RANGE_HI:RANGE_LO])
      RANGE_LOW_CODE:  range = DRIVE_LOW;
      RANGE_MID_CODE:  range = DRIVE_MID;
      RANGE_HIGH_CODE: range = DRIVE_HIGH;
      default:         range = DRIVE_OFF;
    endcase
  end

endmodule : crystal_control
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for system clock source selection and enables
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clock_switch_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic         clock = 1'b0;
  logic         rst_b = 1'b0;
  logic         mode_wr = 1'b0;
  logic [7:0]   mode_wdata = 8'h00;
  logic         xctl_wr = 1'b0;
  logic [7:0]   xctl_wdata = 8'h00;
  logic         crystal_stable = 1'b0;
  logic         calibration_done = 1'b0;
  logic         pin_in = 1'b0;
  logic         pin_b = 1'b1;
  logic [7:0]   mode_q;
  logic [7:0]   xctl_q;
  clk_src_t     src;
  drive_range_t range;
  logic         ls_en;
  logic         hs_en;
  logic         x_en;
  logic         wdt;
  logic         hung;
  logic         ext_rst;
  int           n_fail = 0;
  int           n_compared = 0;
  always #12.5 clock = ~clock;
  system_clock_switching u_system_clock_switching (
    .clock(clock), .rst_b(rst_b), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .xctl_wr(xctl_wr), .xctl_wdata(xctl_wdata),
    .crystal_stable(crystal_stable), .calibration_done(calibration_done),
    .shared_pin_is_input(pin_in), .shared_pin_b(pin_b),
    .clock_mode_register(mode_q), .crystal_control_register(xctl_q),
    .system_clock_source(src), .low_speed_rc_enable(ls_en),
    .high_speed_rc_enable(hs_en), .crystal_enable(x_en),
    .crystal_drive_range(range), .watchdog_active(wdt),
    .core_hung(hung), .external_reset_request(ext_rst));
  // ----------------------------------------------------------------
  // Shared tasks; inputs only ever change at the falling edge
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic do_reset;
    rst_b = 1'b0;
    crystal_stable = 1'b0;
    pin_in = 1'b0;
    pin_b = 1'b1;
    cyc(5);
    rst_b = 1'b1;
    cyc(1);
  endtask : do_reset
  // Register answers on the same edge that takes the strobe
  // One idle edge follows, so a second call never re-raises the strobe
  task automatic wr_mode(input logic [7:0] d);
    mode_wdata = d;
    mode_wr = 1'b1;
    cyc(1);
    mode_wr = 1'b0;
    cyc(1);
  endtask : wr_mode
  task automatic wr_xctl(input logic [7:0] d);
    xctl_wdata = d;
    xctl_wr = 1'b1;
    cyc(1);
    xctl_wr = 1'b0;
    cyc(1);
  endtask : wr_xctl
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    do_reset();
    chk("mode", MODE_RESET, mode_q);
    chk("src", 8'(SRC_LS), 8'(src));
    chk("ls_en", 8'h01, 8'(ls_en));
    chk("hs_en", 8'h01, 8'(hs_en));
    chk("wdt", 8'h01, 8'(wdt));
    chk("xctl", XCTL_RESET, xctl_q);
    chk("hung", 8'h00, 8'(hung));
  endtask : t_reset
  // Safe order: new source first, then the old oscillator off
  task automatic t_safe(input logic [7:0] sel, input clk_src_t exp);
    wr_mode(sel);
    chk("ls kept", 8'h01, 8'(ls_en));
    chk("hs_en", 8'(sel[BIT_HS_EN]), 8'(hs_en));
    cyc(1);
    chk("src", 8'(exp), 8'(src));
    wr_mode(sel & 8'hfb);
    cyc(1);
    chk("ls off", 8'h00, 8'(ls_en));
    chk("wdt off", 8'h00, 8'(wdt));
    chk("no hang", 8'h00, 8'(hung));
    chk("src held", 8'(exp), 8'(src));
  endtask : t_safe
  task automatic t_ranges;
    drive_range_t exp_r[4];
    exp_r = '{DRIVE_OFF, DRIVE_LOW, DRIVE_MID, DRIVE_HIGH};
    for (int i = 0; i < 4; i++) begin
      wr_xctl({1'b1, 2'(i), 5'h00});
      chk("range", 8'(exp_r[i]), 8'(range));
      chk("xctl", {1'b1, 2'(i), 5'h00}, xctl_q);
      chk("x_en", 8'h01, 8'(x_en));
    end
    wr_xctl(8'h40);
    chk("x_en off", 8'h00, 8'(x_en));
    chk("range mid", 8'(DRIVE_MID), 8'(range));
  endtask : t_ranges
  task automatic t_bad;
    do_reset();
    wr_mode(MODE_BAD_SWITCH);
    chk("hung", 8'h01, 8'(hung));
    wr_mode(MODE_TO_HS_DIV2);
    cyc(2);
    chk("frozen mode", MODE_BAD_SWITCH, mode_q);
    chk("frozen src", 8'(SRC_LS), 8'(src));
  endtask : t_bad
  // No stability check: selecting a crystal not yet settled hangs
  task automatic t_unstable;
    do_reset();
    wr_xctl(8'he0);
    wr_mode(MODE_TO_XTAL);
    cyc(2);
    chk("xtal hang", 8'h01, 8'(hung));
  endtask : t_unstable
  task automatic t_calib;
    do_reset();
    calibration_done = 1'b1;
    cyc(1);
    calibration_done = 1'b0;
    chk("wdt cal", 8'h00, 8'(wdt));
    wr_mode(MODE_RESET);
    chk("wdt re-on", 8'h01, 8'(wdt));
  endtask : t_calib
  task automatic t_ext;
    wr_mode(8'hf7);
    pin_in = 1'b1;
    pin_b = 1'b0;
    cyc(1);
    chk("ext on", 8'h01, 8'(ext_rst));
    pin_b = 1'b1;
    cyc(1);
    chk("ext high", 8'h00, 8'(ext_rst));
    pin_b = 1'b0;
    pin_in = 1'b0;
    cyc(1);
    chk("ext out", 8'h00, 8'(ext_rst));
  endtask : t_ext
  // New source on one edge, old oscillator off on the very next edge
  task automatic t_b2b;
    do_reset();
    mode_wdata = MODE_TO_HS_DIV2;
    mode_wr = 1'b1;
    cyc(1);
    mode_wdata = MODE_TO_HS_DIV2 & 8'hfb;
    cyc(1);
    mode_wr = 1'b0;
    cyc(2);
    chk("b2b hung", 8'h00, 8'(hung));
    chk("b2b src", 8'(SRC_HS_DIV2), 8'(src));
    chk("b2b mode", MODE_TO_HS_DIV2 & 8'hfb, mode_q);
    chk("b2b ls off", 8'h00, 8'(ls_en));
  endtask : t_b2b
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    t_reset();
    t_ext();
    t_safe(MODE_TO_HS_DIV2, SRC_HS_DIV2);
    do_reset();
    t_ranges();
    wr_xctl(8'he0);
    crystal_stable = 1'b1;
    cyc(4);
    t_safe(MODE_TO_XTAL, SRC_XTAL);
    t_bad();
    t_unstable();
    t_calib();
    t_b2b();
    close_out();
  end
endmodule : tb
`default_nettype wire
